/* core/cdsd_pkg.sv */
// Package for the core data space decoder: modes, layout, carriers
`default_nettype none
package cdsd_pkg;
  typedef enum logic [2:0] {
    CDSD_MODE_DIRECT   = 3'b000,
    CDSD_MODE_INDIRECT = 3'b001,
    CDSD_MODE_REGISTER = 3'b010,
    CDSD_MODE_BIT      = 3'b011,
    CDSD_MODE_STACK    = 3'b100
  } cdsd_mode_t;

  typedef enum logic [1:0] {
    CDSD_TGT_RAM  = 2'b00,
    CDSD_TGT_SFR  = 2'b01,
    CDSD_TGT_NONE = 2'b10
  } cdsd_tgt_t;

  localparam int CDSD_RAM_BYTES  = 256;
  localparam int CDSD_SFR_BYTES  = 128;
  localparam int CDSD_DATA_BYTES = CDSD_RAM_BYTES + CDSD_SFR_BYTES;
  localparam int CDSD_BANKS      = 4;
  localparam int CDSD_BANK_REGS  = 8;
  localparam logic [7:0] CDSD_BIT_BASE   = 8'h20;
  localparam logic [7:0] CDSD_BIT_LAST   = 8'h2f;
  localparam logic [7:0] CDSD_GEN_BASE   = 8'h30;
  localparam logic [7:0] CDSD_GEN_LAST   = 8'h7f;
  localparam logic [7:0] CDSD_UPPER_BASE = 8'h80;
  localparam int CDSD_CODE_AW   = 16;
  localparam logic [7:0] CDSD_RESET_BYTE = 8'h00;
  localparam logic [1:0] CDSD_RESET_BANK = 2'h0;

  typedef struct packed {
    cdsd_mode_t  mode;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic        wbit;
  } cdsd_req_t;

  typedef struct packed {
    logic        valid;
    cdsd_tgt_t   tgt;
    logic [7:0]  addr;
    logic [7:0]  rdata;
    logic        rbit;
  } cdsd_rsp_t;
endpackage
`default_nettype wire

/* core/cdsd_ram.sv */
// Single-port core RAM with registered read data
`default_nettype none
module cdsd_ram
  import cdsd_pkg::*;
(
  input  wire logic       i_clk,   // Core clock
  input  wire logic       i_we,    // Write strobe
  input  wire logic [7:0] i_addr,  // Byte address
  input  wire logic [7:0] i_wdata, // Write data
  output logic      [7:0] o_rdata  // Registered read data
);
  logic [7:0] mem [CDSD_RAM_BYTES];

  // No reset: RAM content is undefined at power up as in a real array
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule
`default_nettype wire

/* core/cdsd_decoder.sv */
// Core internal data space decoder with core RAM and code fetch routing
`default_nettype none
module cdsd_decoder
  import cdsd_pkg::*;
(
  input  wire logic                    I_SYS_CLK,     // 40 MHz core clock
  input  wire logic                    I_RESET,       // Sync reset, high
  input  wire cdsd_req_t               I_REQ,         // Data access request
  input  wire logic [1:0]              I_BANK_SEL,    // Status reg bank field
  input  wire logic                    I_FETCH,       // Code fetch strobe
  input  wire logic [CDSD_CODE_AW-1:0] I_FETCH_ADDR,  // Code address
  input  wire logic [7:0]              I_SFR_RDATA,   // SFR read data
  output cdsd_rsp_t                    O_RSP,         // Read answer
  output logic                         O_SFR_RD,      // SFR read strobe
  output logic                         O_SFR_WR,      // SFR write strobe
  output logic [6:0]                   O_SFR_ADDR,    // SFR offset
  output logic [7:0]                   O_SFR_WDATA,   // SFR write data
  output logic                         O_FLASH_RD,    // Flash fetch strobe
  output logic [CDSD_CODE_AW-1:0]      O_FLASH_ADDR   // Flash address
);
  // Stage 1 state: decoded access
  logic [7:0] ram_addr;
  logic [7:0] ram_rdata;
  logic       pend;
  cdsd_tgt_t  pend_tgt;
  logic [7:0] pend_addr;
  logic [2:0] pend_bitpos;
  logic       pend_bitmode;
  logic       rmw;
  logic [2:0] rmw_bitpos;
  logic       rmw_bit;

  logic       next_ram_we;
  logic [7:0] next_ram_addr;
  logic [7:0] next_ram_wdata;
  logic       next_pend;
  cdsd_tgt_t  next_pend_tgt;
  logic [7:0] next_pend_addr;
  logic [2:0] next_pend_bitpos;
  logic       next_pend_bitmode;
  logic       next_rmw;
  logic [2:0] next_rmw_bitpos;
  logic       next_rmw_bit;
  logic       next_sfr_rd;
  logic       next_sfr_wr;
  logic [6:0] next_sfr_addr;
  logic [7:0] next_sfr_wdata;
  cdsd_rsp_t  next_rsp;
  logic       next_flash_rd;
  logic [CDSD_CODE_AW-1:0] next_flash_addr;

  cdsd_ram i_cdsd_ram (
    .i_clk   (I_SYS_CLK),
    .i_we    (next_ram_we),
    .i_addr  (next_ram_addr),
    .i_wdata (next_ram_wdata),
    .o_rdata (ram_rdata)
  );

  // Address resolution per mode
  cdsd_tgt_t  tgt;
  logic [7:0] eff;
  logic [2:0] bitpos;
  always_comb begin
    tgt    = CDSD_TGT_RAM;
    eff    = I_REQ.addr;
    bitpos = 3'h0;
    case (I_REQ.mode)
      CDSD_MODE_REGISTER: begin
        eff = {3'h0, I_BANK_SEL, I_REQ.addr[2:0]};
      end
      CDSD_MODE_BIT: begin
        // Bit addresses 0x00-0x7f land in 0x20-0x2f, upper ones in SFRs
        if (I_REQ.addr < CDSD_UPPER_BASE) begin
          eff = CDSD_BIT_BASE | {4'h0, I_REQ.addr[6:3]};
        end else begin
          tgt = CDSD_TGT_SFR;
          eff = {I_REQ.addr[7:3], 3'h0};
        end
        bitpos = I_REQ.addr[2:0];
      end
      CDSD_MODE_DIRECT: begin
        if (I_REQ.addr >= CDSD_UPPER_BASE) begin
          tgt = CDSD_TGT_SFR;
        end
      end
      CDSD_MODE_INDIRECT,
      CDSD_MODE_STACK: begin
        tgt = CDSD_TGT_RAM;
      end
      default: begin
        tgt = CDSD_TGT_NONE;
      end
    endcase
  end

  // RAM port and answer bookkeeping. The array sees the decoded request
  // itself, so its registered read data are ready for the answer stage.
  always_comb begin
    next_ram_we       = 1'b0;
    next_ram_addr     = eff;
    next_ram_wdata    = I_REQ.wdata;
    next_pend         = 1'b0;
    next_pend_tgt     = tgt;
    next_pend_addr    = eff;
    next_pend_bitpos  = bitpos;
    next_pend_bitmode = (I_REQ.mode == CDSD_MODE_BIT);
    next_rmw          = 1'b0;
    next_rmw_bitpos   = bitpos;
    next_rmw_bit      = I_REQ.wbit;
    // Bit writes to RAM take a read-modify-write; finish the write first
    if (rmw) begin
      next_ram_we    = 1'b1;
      next_ram_addr  = ram_addr;
      next_ram_wdata = ram_rdata;
      next_ram_wdata[rmw_bitpos] = rmw_bit;
    end else if (I_REQ.rd || I_REQ.wr) begin
      if (tgt == CDSD_TGT_RAM) begin
        if (I_REQ.wr && I_REQ.mode == CDSD_MODE_BIT) begin
          next_rmw = 1'b1;
        end else begin
          next_ram_we = I_REQ.wr;
        end
        next_pend = I_REQ.rd;
      end else if (tgt == CDSD_TGT_SFR) begin
        next_pend = I_REQ.rd;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      ram_addr     <= CDSD_RESET_BYTE;
      pend         <= 1'b0;
      pend_tgt     <= CDSD_TGT_NONE;
      pend_addr    <= CDSD_RESET_BYTE;
      pend_bitpos  <= 3'h0;
      pend_bitmode <= 1'b0;
      rmw          <= 1'b0;
      rmw_bitpos   <= 3'h0;
      rmw_bit      <= 1'b0;
    end else begin
      ram_addr     <= next_ram_addr;
      pend         <= next_pend;
      pend_tgt     <= next_pend_tgt;
      pend_addr    <= next_pend_addr;
      pend_bitpos  <= next_pend_bitpos;
      pend_bitmode <= next_pend_bitmode;
      rmw          <= next_rmw;
      rmw_bitpos   <= next_rmw_bitpos;
      rmw_bit      <= next_rmw_bit;
    end
  end

  // Special function region strobes; a bit write goes out as a whole byte
  // with only the addressed bit placed, and the far side stores it as the whole byte
  always_comb begin
    next_sfr_rd    = 1'b0;
    next_sfr_wr    = 1'b0;
    next_sfr_addr  = eff[6:0];
    next_sfr_wdata = I_REQ.wdata;
    if (!rmw && tgt == CDSD_TGT_SFR) begin
      next_sfr_rd = I_REQ.rd;
      next_sfr_wr = I_REQ.wr;
      if (I_REQ.mode == CDSD_MODE_BIT) begin
        next_sfr_wdata = {7'h0, I_REQ.wbit} << bitpos;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_SFR_RD    <= 1'b0;
      O_SFR_WR    <= 1'b0;
      O_SFR_ADDR  <= 7'h0;
      O_SFR_WDATA <= CDSD_RESET_BYTE;
    end else begin
      O_SFR_RD    <= next_sfr_rd;
      O_SFR_WR    <= next_sfr_wr;
      O_SFR_ADDR  <= next_sfr_addr;
      O_SFR_WDATA <= next_sfr_wdata;
    end
  end

  // Answer stage: RAM data come from the array register, region data from
  // the far side in the same cycle as the read strobe
  always_comb begin
    next_rsp      = '0;
    next_rsp.tgt  = pend_tgt;
    next_rsp.addr = pend_addr;
    if (pend) begin
      next_rsp.valid = 1'b1;
      next_rsp.rdata = (pend_tgt == CDSD_TGT_SFR) ? I_SFR_RDATA : ram_rdata;
      next_rsp.rbit  = pend_bitmode ? next_rsp.rdata[pend_bitpos] : 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_RSP <= '0;
    end else begin
      O_RSP <= next_rsp;
    end
  end

  // Code fetch: the whole space is main flash, so the address passes
  // unchanged; it is only registered to keep the outputs on flops
  always_comb begin
    next_flash_rd   = I_FETCH;
    next_flash_addr = I_FETCH_ADDR;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      O_FLASH_RD   <= 1'b0;
      O_FLASH_ADDR <= '0;
    end else begin
      O_FLASH_RD   <= next_flash_rd;
      O_FLASH_ADDR <= next_flash_addr;
    end
  end
endmodule
`default_nettype wire

/* verification/cdsd_decoder_sva.sv */
// Checker for the core data space decoder ports
`default_nettype none
module cdsd_decoder_sva
  import cdsd_pkg::*;
(
  input wire logic                    I_SYS_CLK,
  input wire logic                    I_RESET,
  input wire cdsd_req_t               I_REQ,
  input wire logic [1:0]              I_BANK_SEL,
  input wire logic                    I_FETCH,
  input wire logic [CDSD_CODE_AW-1:0] I_FETCH_ADDR,
  input wire logic [7:0]              I_SFR_RDATA,
  input wire cdsd_rsp_t               O_RSP,
  input wire logic                    O_SFR_RD,
  input wire logic                    O_SFR_WR,
  input wire logic [6:0]              O_SFR_ADDR,
  input wire logic [7:0]              O_SFR_WDATA,
  input wire logic                    O_FLASH_RD,
  input wire logic [CDSD_CODE_AW-1:0] O_FLASH_ADDR
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);
  // Reads right after a write are skipped: a RAM bit write swallows them
  sequence s_rd(cdsd_mode_t m);
    I_REQ.rd && !I_REQ.wr && I_REQ.mode == m && !$past(I_REQ.wr);
  endsequence
  sequence s_ram(logic [7:0] a);
    ##2 O_RSP.valid && O_RSP.tgt == CDSD_TGT_RAM && O_RSP.addr == a;
  endsequence
  chk_low_direct: assert property (
    s_rd(CDSD_MODE_DIRECT) ##0 !I_REQ.addr[7]
    |-> s_ram($past(I_REQ.addr, 2))) else $error("lower direct read");
  chk_upper_ind: assert property (
    s_rd(CDSD_MODE_INDIRECT) ##0 I_REQ.addr[7] |-> ##1 !O_SFR_RD ##1
    O_RSP.tgt == CDSD_TGT_RAM && O_RSP.addr == $past(I_REQ.addr, 2))
    else $error("upper indirect read");
  chk_stack_ram: assert property (
    s_rd(CDSD_MODE_STACK) |-> s_ram($past(I_REQ.addr, 2)))
    else $error("stack read");
  chk_sfr_direct: assert property (
    s_rd(CDSD_MODE_DIRECT) ##0 I_REQ.addr[7]
    |=> O_SFR_RD && O_SFR_ADDR == $past(I_REQ.addr[6:0]))
    else $error("sfr read strobe");
  chk_sfr_answer: assert property (
    O_SFR_RD |=> O_RSP.valid && O_RSP.tgt == CDSD_TGT_SFR
    && O_RSP.rdata == $past(I_SFR_RDATA)) else $error("sfr read data");
  chk_sfr_write: assert property (
    I_REQ.wr && I_REQ.mode == CDSD_MODE_DIRECT && I_REQ.addr[7]
    && !$past(I_REQ.wr) |=> O_SFR_WR && O_SFR_WDATA == $past(I_REQ.wdata))
    else $error("sfr write");
  chk_bank_pick: assert property (
    s_rd(CDSD_MODE_REGISTER) |-> s_ram({3'h0, $past(I_BANK_SEL, 2),
    $past(I_REQ.addr[2:0], 2)})) else $error("register bank");
  chk_bit_byte: assert property (
    s_rd(CDSD_MODE_BIT) ##0 !I_REQ.addr[7]
    |-> s_ram({4'h2, $past(I_REQ.addr[6:3], 2)})) else $error("bit byte");
  chk_fetch_flash: assert property (
    I_FETCH |=> O_FLASH_RD && O_FLASH_ADDR == $past(I_FETCH_ADDR))
    else $error("code fetch");
endmodule
bind cdsd_decoder cdsd_decoder_sva i_chk (.I_SYS_CLK, .I_RESET, .I_REQ,
  .I_BANK_SEL, .I_FETCH, .I_FETCH_ADDR, .I_SFR_RDATA, .O_RSP, .O_SFR_RD,
  .O_SFR_WR, .O_SFR_ADDR, .O_SFR_WDATA, .O_FLASH_RD, .O_FLASH_ADDR);
`default_nettype wire

/* verification/cdsd_sfr_model.sv */
// Model of the special function region behind the decoder strobes
`default_nettype none
module cdsd_sfr_model (
  input  wire logic       i_clk,   // Core clock
  input  wire logic       i_rd,    // Read strobe
  input  wire logic       i_wr,    // Write strobe
  input  wire logic [6:0] i_addr,  // Register offset
  input  wire logic [7:0] i_wdata, // Write data
  output logic      [7:0] o_rdata  // Read data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [128];
  // Outside a read the bus shows inverted data, so a late sample shows up
  assign o_rdata = i_rd ? mem[i_addr] : ~mem[i_addr];
  always_ff @(posedge i_clk) if (i_wr) mem[i_addr] <= i_wdata;
endmodule
`default_nettype wire

/* verification/cdsd_decoder_bench.sv */
// Self-checking bench for the core data space decoder
`default_nettype none
module cdsd_decoder_bench
  import cdsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, fetch, sfr_rd, sfr_wr, flash_rd;
  logic [1:0]  bank;
  logic [15:0] faddr, flash_addr;
  logic [7:0]  sfr_rdata, sfr_wdata;
  logic [6:0]  sfr_addr;
  cdsd_req_t   req;
  cdsd_rsp_t   rsp;
  int          bad_count, checked;
  cdsd_decoder i_cdsd_decoder (.I_SYS_CLK(clk), .I_RESET(rst), .I_REQ(req),
    .I_BANK_SEL(bank), .I_FETCH(fetch), .I_FETCH_ADDR(faddr),
    .I_SFR_RDATA(sfr_rdata), .O_RSP(rsp), .O_SFR_RD(sfr_rd),
    .O_SFR_WR(sfr_wr), .O_SFR_ADDR(sfr_addr), .O_SFR_WDATA(sfr_wdata),
    .O_FLASH_RD(flash_rd), .O_FLASH_ADDR(flash_addr));
  cdsd_sfr_model i_cdsd_sfr_model (.i_clk(clk), .i_rd(sfr_rd),
    .i_wr(sfr_wr), .i_addr(sfr_addr), .i_wdata(sfr_wdata),
    .o_rdata(sfr_rdata));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One access; a write is followed by an idle cycle for the bit-write slot
  task automatic acc(cdsd_mode_t m, logic [7:0] a, logic w, logic [7:0] d,
                     logic b = 1'b0);
    int n;
    @(posedge clk) req <= '{m, a, !w, w, d, b};
    @(posedge clk) req <= '0;
    n = 0;
    if (w) @(posedge clk);
    else begin
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (rsp.valid !== 1'b1 && n < 4);
      if (rsp.valid !== 1'b1) begin
        bad_count++;
        finish_test();
      end
    end
  endtask
  task automatic t_lower();
    logic [7:0] la [4] = '{8'h00, 8'h2f, 8'h30, 8'h7f};
    foreach (la[i]) begin
      acc(CDSD_MODE_DIRECT, la[i], 1, la[i] ^ 8'h5a);
      acc(CDSD_MODE_INDIRECT, la[i], 0, 8'h00);
      chk("ram_low", rsp.rdata, la[i] ^ 8'h5a);
    end
    $display("test lower done");
  endtask
  task automatic t_upper();
    acc(CDSD_MODE_INDIRECT, 8'h90, 1, 8'h3c);
    acc(CDSD_MODE_DIRECT, 8'h90, 1, 8'hc3);
    acc(CDSD_MODE_STACK, 8'hff, 1, 8'h77);
    acc(CDSD_MODE_INDIRECT, 8'h90, 0, 8'h00);
    chk("ram_up", rsp.rdata, 8'h3c);
    acc(CDSD_MODE_DIRECT, 8'h90, 0, 8'h00);
    chk("sfr_data", rsp.rdata, 8'hc3);
    chk("sfr_tgt", {6'h0, rsp.tgt}, {6'h0, CDSD_TGT_SFR});
    acc(CDSD_MODE_INDIRECT, 8'hff, 0, 8'h00);
    chk("stack", rsp.rdata, 8'h77);
    acc(CDSD_MODE_STACK, 8'h90, 0, 8'h00);
    chk("pop", rsp.rdata, 8'h3c);
    acc(CDSD_MODE_BIT, 8'h96, 0, 8'h00);
    chk("sfr_bit", {7'h0, rsp.rbit}, 8'h01);
    $display("test upper done");
  endtask
  task automatic t_bank();
    for (int b = 0; b < 4; b++) begin
      @(posedge clk) bank <= b[1:0];
      acc(CDSD_MODE_REGISTER, 8'h07, 1, 8'h10 + b[7:0]);
      acc(CDSD_MODE_INDIRECT, {3'h0, b[1:0], 3'h7}, 0, 8'h00);
      chk("bank", rsp.rdata, 8'h10 + b[7:0]);
      acc(CDSD_MODE_REGISTER, 8'h07, 0, 8'h00);
      chk("bank_rd", rsp.rdata, 8'h10 + b[7:0]);
    end
    $display("test bank done");
  endtask
  task automatic t_bit();
    acc(CDSD_MODE_DIRECT, 8'h21, 1, 8'h00);
    acc(CDSD_MODE_BIT, 8'h0b, 1, 8'h00, 1'b1);
    acc(CDSD_MODE_DIRECT, 8'h21, 0, 8'h00);
    chk("bit_set", rsp.rdata, 8'h08);
    acc(CDSD_MODE_BIT, 8'h0b, 0, 8'h00);
    chk("bit_rd", {7'h0, rsp.rbit}, 8'h01);
    $display("test bit done");
  endtask
  task automatic t_fetch();
    @(posedge clk) begin
      fetch <= 1'b1;
      faddr <= 16'ha5c3;
    end
    @(posedge clk) fetch <= 1'b0;
    #1;
    chk("flash_rd", {7'h0, flash_rd}, 8'h01);
    chk("flash_hi", flash_addr[15:8], 8'ha5);
    chk("flash_lo", flash_addr[7:0], 8'hc3);
    @(posedge clk);
    #1;
    chk("flash_end", {7'h0, flash_rd}, 8'h00);
    $display("test fetch done");
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    req = '0;
    bank = 2'h0;
    fetch = 1'b0;
    faddr = 16'hffff;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_lower();
    t_upper();
    t_bank();
    t_bit();
    t_fetch();
    finish_test();
  end
endmodule
`default_nettype wire
